// [src/cltd_pkg.sv]
/*
 * Shared constants and types of the control, literal and table
 * instruction decoder: APB register map, field positions, reset values,
 * opcode patterns and sequencing states.
 * Assumes a single 50 MHz core clock and an APB master for software access.
 */
package cltd_pkg;
    // Core clock and table write timing
    localparam int CLK_MHZ = 50;
    localparam logic [2:0] TBLW_EXTRA_CYCLES = 3'h3;
    // APB register byte offsets
    localparam logic [7:0] REG_CORE_STATE = 8'h00;
    localparam logic [7:0] REG_PROG_COUNTER = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_TABLE_PTR = 8'h0C;
    // Config register fields and reset value
    localparam int CFG_PRESCALER_ASSIGNED = 0;
    localparam int CFG_NVM_WRITE_ENABLE = 1;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    // Status flag positions inside flags vector
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    // Reset values
    localparam logic [19:0] PC_RESET = 20'h00000;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [7:0] WORKING_REGISTER_RESET = 8'h00;
    localparam int STACK_DEPTH = 8;
    // Opcode patterns
    localparam logic [3:0] OP_SECOND_WORD = 4'hF;
    localparam logic [4:0] OP_COND_BRANCH = 5'h1C;
    localparam logic [3:0] OP_REL_BRANCH = 4'hD;
    localparam logic [6:0] OP_ABS_CALL = 7'h76;
    localparam logic [7:0] OP_ABS_JUMP = 8'hEF;
    localparam logic [7:0] OP_PTR_LOAD = 8'hEE;
    localparam logic [7:0] OP_MISC = 8'h00;
    localparam logic [7:0] OP_BANK_LOAD = 8'h01;
    localparam logic [7:0] OP_RET_LITERAL = 8'h0C;
    localparam logic [7:0] OP_LIT_ADD = 8'h0F;
    localparam logic [7:0] OP_LIT_SUB = 8'h08;
    localparam logic [7:0] OP_LIT_AND = 8'h0B;
    localparam logic [7:0] OP_LIT_OR = 8'h09;
    localparam logic [7:0] OP_LIT_XOR = 8'h0A;
    localparam logic [7:0] OP_LIT_LOAD = 8'h0E;
    localparam logic [7:0] OP_LIT_MUL = 8'h0D;
    localparam logic [7:0] LO_STANDBY = 8'h03;
    localparam logic [7:0] LO_WDT_CLEAR = 8'h04;
    localparam logic [7:0] LO_PUSH = 8'h05;
    localparam logic [7:0] LO_POP = 8'h06;
    localparam logic [7:0] LO_SOFT_RESET = 8'hFF;
    localparam logic [5:0] LO_TABLE_READ = 6'h02;
    localparam logic [5:0] LO_TABLE_WRITE = 6'h03;
    localparam logic [6:0] LO_IRQ_RETURN = 7'h08;
    localparam logic [6:0] LO_SUB_RETURN = 7'h09;
    // Table pointer modes
    localparam logic [1:0] TP_POST_INC = 2'h1;
    localparam logic [1:0] TP_POST_DEC = 2'h2;
    localparam logic [1:0] TP_PRE_INC = 2'h3;

    typedef enum logic [2:0] {
        ST_EXEC,
        ST_FLUSH,
        ST_WORD2,
        ST_TBL_READ,
        ST_TBL_WRITE,
        ST_STANDBY
    } cltd_state_type;
endpackage

// [src/cltd_decoder.sv]
/*
 * Decoder and executor for control-flow, literal and table-access
 * instructions, with an APB slave for status and configuration.
 * Assumes program memory returns the word at fetch_addr combinationally
 * in the same cycle, and the core datapath handles every other opcode.
 */
// Operation
// - 1110 0ccc conditional branch, eight conditions
// - 1101 relative branch or relative call
// - Two-word absolute call, s saves fast registers
// - Two-word absolute jump, two cycles
// - Lone 1111 word or zero word: no-op
// - PC change or true test costs two cycles
// - Watchdog clear and standby update timeout flags
// - One-cycle push and pop of return stack
// - Software reset restores full reset state
// - Interrupt return re-enables interrupts, optional restore
// - Subroutine return, optional fast restore
// - Literal return loads working register
// - Literal add and subtract set arithmetic flags
// - Literal and, or, xor set Z, N
// - Literal load and multiply change no flags
// - Bank select low nibble load
// - Two-word 12-bit pointer literal load
// - Table read with four pointer modes
// - Table write two cycles, five when writing
// - Started memory write runs until terminated
// - Port read-modify-write uses pin levels
// - Timer zero write clears assigned prescaler
module cltd_decoder
    import cltd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic wake_event,
    input wire logic [7:0] table_rdata,
    input wire logic nvm_done,
    input wire logic [7:0] port_pins,
    input wire logic timer_zero_write,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [19:0] fetch_addr,
    output logic [19:0] table_addr,
    output logic table_read,
    output logic table_write,
    output logic [7:0] table_wdata,
    output logic nvm_write,
    output logic wdt_clear,
    output logic standby,
    output logic soft_reset,
    output logic [7:0] port_readback,
    output logic prescaler_clear,
    output logic [15:0] product,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    import cltd_pkg::*;

    typedef struct packed {
        cltd_state_type st;
        logic [19:0] pc;
        logic [15:0] hold;
        logic [7:0] working_register;
        logic [4:0] flags;
        logic [3:0] bank;
        logic [2:0][11:0] ptr;
        logic [STACK_DEPTH-1:0][19:0] stack;
        logic [2:0] sp;
        logic [7:0] fast_w;
        logic [4:0] fast_flags;
        logic [3:0] fast_bank;
        logic timeout_flag;
        logic power_down_flag;
        logic global_high_irq_enable;
        logic peripheral_low_irq_enable;
        logic [19:0] tblptr;
        logic [7:0] tablat;
        logic [2:0] wait_cnt;
        logic [1:0] config_bits;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pins;
        logic [19:0] table_addr;
        logic table_read;
        logic table_write;
        logic nvm_write;
        logic wdt_clear;
        logic soft_reset;
        logic standby;
        logic prescaler_clear;
        logic [15:0] product;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } cltd_regs_type;

    localparam cltd_regs_type REGS_RESET = '{
        st: ST_EXEC, pc: PC_RESET, working_register: WORKING_REGISTER_RESET, flags: FLAGS_RESET,
        timeout_flag: 1'b1, power_down_flag: 1'b1,
        config_bits: CONFIG_RESET, default: '0};

    cltd_regs_type s_q;
    cltd_regs_type s_d;

    logic [19:0] pc_next;
    logic [19:0] short_target;
    logic [19:0] long_target;
    logic [19:0] far_addr;
    logic [7:0] lit;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] logic_res;
    logic cond_flag;
    logic [2:0] sp_up;
    logic [2:0] sp_dn;

    // Branch targets relative to the following word
    always_comb
    begin
        lit = instr_word[7:0];
        pc_next = s_q.pc + 20'h00001;
        short_target = pc_next + {{12{lit[7]}}, lit};
        long_target = pc_next
            + {{9{instr_word[10]}}, instr_word[10:0]};
        far_addr = {s_q.hold[7:0], instr_word[11:0]};
        sp_up = s_q.sp + 3'h1;
        sp_dn = s_q.sp - 3'h1;
        case (instr_word[10:9])
            2'h0: cond_flag = s_q.flags[FLAG_Z];
            2'h1: cond_flag = s_q.flags[FLAG_C];
            2'h2: cond_flag = s_q.flags[FLAG_OV];
            default: cond_flag = s_q.flags[FLAG_N];
        endcase
        case (instr_word[15:8])
            OP_LIT_AND: logic_res = s_q.working_register & lit;
            OP_LIT_OR: logic_res = s_q.working_register | lit;
            default: logic_res = s_q.working_register ^ lit;
        endcase
        if (instr_word[15:8] == OP_LIT_SUB)
        begin
            sum = {1'b0, lit} + {1'b0, ~s_q.working_register} + 9'h001;
            nib = {1'b0, lit[3:0]} + {1'b0, ~s_q.working_register[3:0]} + 5'h01;
        end
        else
        begin
            sum = {1'b0, lit} + {1'b0, s_q.working_register};
            nib = {1'b0, lit[3:0]} + {1'b0, s_q.working_register[3:0]};
        end
    end

    // Next-state logic for sequencing, execution and the APB slave
    always_comb
    begin
        s_d = s_q;
        s_d.table_read = 1'b0;
        s_d.table_write = 1'b0;
        s_d.wdt_clear = 1'b0;
        s_d.soft_reset = 1'b0;
        s_d.prescaler_clear = 1'b0;
        // Pin synchroniser, change accepted when stages two and three agree
        s_d.pin_s1 = port_pins;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;
        if (s_q.pin_s2 == s_q.pin_s3)
        begin
            s_d.pins = s_q.pin_s3;
        end
        // Prescaler cleared on timer zero write when assigned to it
        if (timer_zero_write && s_q.config_bits[CFG_PRESCALER_ASSIGNED])
        begin
            s_d.prescaler_clear = 1'b1;
        end
        // Memory write stays active until the memory terminates it
        if (nvm_done)
        begin
            s_d.nvm_write = 1'b0;
        end
        case (s_q.st)
            ST_EXEC:
            begin
                s_d.pc = pc_next;
                if (instr_word[15:12] == OP_SECOND_WORD)
                begin
                    s_d.pc = pc_next;
                end
                else if (instr_word[15:11] == OP_COND_BRANCH)
                begin
                    if (cond_flag ^ instr_word[8])
                    begin
                        s_d.pc = short_target;
                        s_d.st = ST_FLUSH;
                    end
                end
                else if (instr_word[15:12] == OP_REL_BRANCH)
                begin
                    s_d.pc = long_target;
                    s_d.st = ST_FLUSH;
                    if (instr_word[11])
                    begin
                        s_d.stack[s_q.sp] = pc_next;
                        s_d.sp = sp_up;
                    end
                end
                else if (instr_word[15:9] == OP_ABS_CALL
                    || instr_word[15:8] == OP_ABS_JUMP
                    || instr_word[15:8] == OP_PTR_LOAD)
                begin
                    s_d.hold = instr_word;
                    s_d.st = ST_WORD2;
                end
                else if (instr_word[15:8] == OP_MISC)
                begin
                    if (lit == LO_STANDBY)
                    begin
                        s_d.timeout_flag = 1'b1;
                        s_d.power_down_flag = 1'b0;
                        s_d.st = ST_STANDBY;
                    end
                    else if (lit == LO_WDT_CLEAR)
                    begin
                        s_d.timeout_flag = 1'b1;
                        s_d.power_down_flag = 1'b1;
                        s_d.wdt_clear = 1'b1;
                    end
                    else if (lit == LO_PUSH)
                    begin
                        s_d.stack[s_q.sp] = pc_next;
                        s_d.sp = sp_up;
                    end
                    else if (lit == LO_POP)
                    begin
                        s_d.sp = sp_dn;
                    end
                    else if (lit == LO_SOFT_RESET)
                    begin
                        s_d = REGS_RESET;
                        s_d.soft_reset = 1'b1;
                    end
                    else if (lit[7:2] == LO_TABLE_READ)
                    begin
                        s_d.table_read = 1'b1;
                        s_d.st = ST_TBL_READ;
                        s_d.table_addr = (lit[1:0] == TP_PRE_INC)
                            ? s_q.tblptr + 20'h00001 : s_q.tblptr;
                        s_d.tblptr = (lit[1:0] == TP_POST_DEC)
                            ? s_q.tblptr - 20'h00001
                            : (lit[1:0] == 2'h0) ? s_q.tblptr
                            : s_q.tblptr + 20'h00001;
                    end
                    else if (lit[7:2] == LO_TABLE_WRITE)
                    begin
                        s_d.table_write = 1'b1;
                        s_d.st = ST_FLUSH;
                        s_d.table_addr = (lit[1:0] == TP_PRE_INC)
                            ? s_q.tblptr + 20'h00001 : s_q.tblptr;
                        s_d.tblptr = (lit[1:0] == TP_POST_DEC)
                            ? s_q.tblptr - 20'h00001
                            : (lit[1:0] == 2'h0) ? s_q.tblptr
                            : s_q.tblptr + 20'h00001;
                        if (s_q.config_bits[CFG_NVM_WRITE_ENABLE])
                        begin
                            s_d.nvm_write = 1'b1;
                            s_d.wait_cnt = TBLW_EXTRA_CYCLES;
                            s_d.st = ST_TBL_WRITE;
                        end
                    end
                    else if (lit[7:1] == LO_IRQ_RETURN
                        || lit[7:1] == LO_SUB_RETURN)
                    begin
                        s_d.pc = s_q.stack[sp_dn];
                        s_d.sp = sp_dn;
                        s_d.st = ST_FLUSH;
                        if (lit[7:1] == LO_IRQ_RETURN)
                        begin
                            s_d.global_high_irq_enable = 1'b1;
                            s_d.peripheral_low_irq_enable = 1'b1;
                        end
                        if (lit[0])
                        begin
                            s_d.working_register = s_q.fast_w;
                            s_d.flags = s_q.fast_flags;
                            s_d.bank = s_q.fast_bank;
                        end
                    end
                end
                else if (instr_word[15:8] == OP_BANK_LOAD
                    && instr_word[7:4] == 4'h0)
                begin
                    s_d.bank = instr_word[3:0];
                end
                else if (instr_word[15:8] == OP_RET_LITERAL)
                begin
                    s_d.working_register = lit;
                    s_d.pc = s_q.stack[sp_dn];
                    s_d.sp = sp_dn;
                    s_d.st = ST_FLUSH;
                end
                else if (instr_word[15:8] == OP_LIT_ADD
                    || instr_word[15:8] == OP_LIT_SUB)
                begin
                    s_d.working_register = sum[7:0];
                    s_d.flags[FLAG_C] = sum[8];
                    s_d.flags[FLAG_DC] = nib[4];
                    s_d.flags[FLAG_Z] = (sum[7:0] == 8'h00);
                    s_d.flags[FLAG_N] = sum[7];
                    if (instr_word[15:8] == OP_LIT_ADD)
                    begin
                        s_d.flags[FLAG_OV] = (lit[7] == s_q.working_register[7])
                            && (sum[7] != lit[7]);
                    end
                    else
                    begin
                        s_d.flags[FLAG_OV] = (lit[7] != s_q.working_register[7])
                            && (sum[7] != lit[7]);
                    end
                end
                else if (instr_word[15:8] == OP_LIT_AND
                    || instr_word[15:8] == OP_LIT_OR
                    || instr_word[15:8] == OP_LIT_XOR)
                begin
                    s_d.working_register = logic_res;
                    s_d.flags[FLAG_Z] = (logic_res == 8'h00);
                    s_d.flags[FLAG_N] = logic_res[7];
                end
                else if (instr_word[15:8] == OP_LIT_LOAD)
                begin
                    s_d.working_register = lit;
                end
                else if (instr_word[15:8] == OP_LIT_MUL)
                begin
                    s_d.product = {8'h00, lit} * {8'h00, s_q.working_register};
                end
            end
            ST_WORD2:
            begin
                s_d.st = ST_EXEC;
                s_d.pc = pc_next;
                if (s_q.hold[15:8] == OP_PTR_LOAD)
                begin
                    if (s_q.hold[5:4] != 2'h3)
                    begin
                        s_d.ptr[s_q.hold[5:4]] = {s_q.hold[3:0], lit};
                    end
                end
                else
                begin
                    s_d.pc = far_addr;
                    if (s_q.hold[15:9] == OP_ABS_CALL)
                    begin
                        s_d.stack[s_q.sp] = pc_next;
                        s_d.sp = sp_up;
                        if (s_q.hold[8])
                        begin
                            s_d.fast_w = s_q.working_register;
                            s_d.fast_flags = s_q.flags;
                            s_d.fast_bank = s_q.bank;
                        end
                    end
                end
            end
            ST_TBL_READ:
            begin
                s_d.tablat = table_rdata;
                s_d.st = ST_EXEC;
            end
            ST_TBL_WRITE:
            begin
                s_d.wait_cnt = s_q.wait_cnt - 3'h1;
                if (s_q.wait_cnt == 3'h1)
                begin
                    s_d.st = ST_FLUSH;
                end
            end
            ST_STANDBY:
            begin
                if (wake_event)
                begin
                    s_d.st = ST_EXEC;
                end
            end
            default:
            begin
                s_d.st = ST_EXEC;
            end
        endcase
        // APB slave, no wait state, data prepared in the setup cycle
        s_d.pready = psel && !penable;
        if (psel && !penable)
        begin
            s_d.prdata = 32'h00000000;
            s_d.pslverr = 1'b0;
            if (paddr == REG_CORE_STATE)
            begin
                s_d.prdata[20:0] = {s_q.bank,
                    s_q.peripheral_low_irq_enable,
                    s_q.global_high_irq_enable, s_q.power_down_flag,
                    s_q.timeout_flag, s_q.flags, s_q.working_register};
            end
            else if (paddr == REG_PROG_COUNTER)
            begin
                s_d.prdata[19:0] = s_q.pc;
            end
            else if (paddr == REG_CONFIG)
            begin
                s_d.prdata[1:0] = s_q.config_bits;
            end
            else if (paddr == REG_TABLE_PTR)
            begin
                s_d.prdata[19:0] = s_q.tblptr;
            end
            else
            begin
                s_d.pslverr = 1'b1;
            end
        end
        if (psel && penable && s_q.pready && pwrite)
        begin
            if (paddr == REG_CONFIG)
            begin
                s_d.config_bits = pwdata[1:0];
            end
            else if (paddr == REG_TABLE_PTR && s_q.st == ST_EXEC)
            begin
                s_d.tblptr = pwdata[19:0];
            end
        end
        // Standby output registered with the state
        s_d.standby = (s_d.st == ST_STANDBY);
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_q <= REGS_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign fetch_addr = s_q.pc;
    assign table_addr = s_q.table_addr;
    assign table_read = s_q.table_read;
    assign table_write = s_q.table_write;
    assign table_wdata = s_q.tablat;
    assign nvm_write = s_q.nvm_write;
    assign wdt_clear = s_q.wdt_clear;
    assign standby = s_q.standby;
    assign soft_reset = s_q.soft_reset;
    assign port_readback = s_q.pins;
    assign prescaler_clear = s_q.prescaler_clear;
    assign product = s_q.product;
    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
endmodule

// [testbench/cltd_prog_mem.sv]
/*
 * Program memory model: fixed test program, table bytes, memory write.
 * Assumes the decoder reads instr_word in the cycle fetch_addr is shown.
 */
module cltd_prog_mem
    import cltd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [19:0] fetch_addr,
    input wire logic [19:0] table_addr,
    input wire logic nvm_write,
    output logic [15:0] instr_word,
    output logic table_rdata_unused,
    output logic [7:0] table_rdata,
    output logic nvm_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rom [0:31];
    logic [2:0] cnt_q;
    // Test program, unused words are zero no-ops
    initial
    begin
        rom = '{16'h0003, 16'h0E85, 16'h0F7B, 16'h09F0, 16'hE301,
            16'hE201, 16'h0E11, 16'h000B, 16'h000C, 16'h0004,
            16'h0105, 16'hEF00, 16'hF010, 16'h0E22, 16'h0000, 16'h0000,
            16'h0003, 16'hEC00, 16'hF018, 16'hD808, 16'hD7FF, 16'h0000,
            16'h0000, 16'h0000, 16'h0D03, 16'h0812, 16'h0012, 16'h0000,
            16'h0010, 16'h0000, 16'h0000, 16'h0000};
    end
    // Words beyond the program read as zero
    assign instr_word = (fetch_addr < 20'h00020)
        ? rom[fetch_addr[4:0]] : 16'h0000;
    assign table_rdata = table_addr[7:0] ^ 8'h5A;
    assign table_rdata_unused = 1'b0;
    // Memory write ends five cycles after it starts
    always_ff @(posedge clk)
    begin
        cnt_q <= (rst || !nvm_write) ? 3'h0 : cnt_q + 3'h1;
        nvm_done <= !rst && nvm_write && cnt_q == 3'h4;
    end
endmodule

// [testbench/cltd_decoder_props.sv]
/*
 * Port checker of the decoder.
 * Assumes binding onto the decoder; one clock, synchronous reset.
 */
module cltd_decoder_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic wake_event,
    input wire logic nvm_done,
    input wire logic [7:0] port_pins,
    input wire logic timer_zero_write,
    input wire logic [19:0] fetch_addr,
    input wire logic table_read,
    input wire logic table_write,
    input wire logic [7:0] table_wdata,
    input wire logic [7:0] table_rdata,
    input wire logic nvm_write,
    input wire logic wdt_clear,
    input wire logic standby,
    input wire logic [7:0] port_readback,
    input wire logic prescaler_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_WDT_PULSE: assert property (wdt_clear |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
    AST_STANDBY_HOLD: assert property (
        standby && !wake_event |=> standby)
        else $error("standby left without wake");
    AST_STANDBY_PC: assert property (
        standby ##1 standby |-> $stable(fetch_addr))
        else $error("fetch moved in standby");
    AST_NVM_HOLD: assert property (
        nvm_write && !nvm_done |=> nvm_write)
        else $error("memory write dropped early");
    AST_NVM_START: assert property ($rose(nvm_write) |-> table_write)
        else $error("memory write without table write");
    AST_PRESCALER: assert property (
        prescaler_clear |-> $past(timer_zero_write))
        else $error("prescaler clear without timer write");
    AST_READBACK: assert property (
        $stable(port_pins)[*6] |-> port_readback == port_pins)
        else $error("readback differs from pins");
    AST_TBL_READ: assert property (
        table_read |-> ##[1:2] table_wdata == table_rdata)
        else $error("table byte not latched");
endmodule

// [testbench/testbench.sv]
/*
 * Testbench: runs a short program and checks results against a model.
 * Assumes the program model and checker files are compiled first.
 */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import cltd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wake_event = 0, nvm_done, timer_zero_write = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, perr;
    logic table_read, table_write, nvm_write, wdt_clear, standby;
    logic soft_reset, prescaler_clear;
    logic [7:0] paddr = 0, table_rdata, table_wdata, port_readback;
    logic [7:0] port_pins = 0;
    logic [15:0] instr_word, product;
    logic [19:0] fetch_addr, table_addr;
    logic [31:0] pwdata = 0, prdata, rd, p;
    integer seed = 32'h2164, fail_count = 0, compares = 0, cyc = 0;
    integer wdt_n = 0, tw_n = 0, w, s, c, dc, z, ov, n;
    always #10 clk = ~clk;
    cltd_decoder dut (.clk, .rst, .instr_word, .wake_event, .table_rdata,
        .nvm_done, .port_pins, .timer_zero_write, .psel, .penable, .pwrite,
        .paddr, .pwdata, .fetch_addr, .table_addr, .table_read, .table_write,
        .table_wdata, .nvm_write, .wdt_clear, .standby, .soft_reset,
        .port_readback, .prescaler_clear, .product, .pready, .prdata,
        .pslverr);
    cltd_prog_mem mem (.clk, .rst, .fetch_addr, .table_addr, .nvm_write,
        .instr_word, .table_rdata_unused(), .table_rdata, .nvm_done);
    task end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One APB transfer, held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Pulse counters and hang limit
    always @(posedge clk)
    begin
        wdt_n += (wdt_clear === 1'b1);
        tw_n += (table_write === 1'b1);
        cyc++;
        if (cyc > 4000)
        begin
            fail_count++;
            end_sim();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 0;
        apb(1, REG_CONFIG, 32'h3);
        apb(0, REG_CONFIG, 0);
        `CHK(rd, 32'h3)
        apb(0, 8'h10, 0);
        `CHK(perr, 1'b1)
        `CHK(standby, 1'b1)
        timer_zero_write <= 1;
        @(posedge clk);
        timer_zero_write <= 0;
        @(posedge clk);
        `CHK(prescaler_clear, 1'b1)
        wake_event <= 1;
        @(posedge clk);
        wake_event <= 0;
        repeat (3)
        begin
            p = $random(seed);
            port_pins <= p[7:0];
            repeat (6) @(posedge clk);
            `CHK(port_readback, p[7:0])
        end
        // Second standby follows the absolute jump
        while (standby !== 1'b1) @(posedge clk);
        // Model of the literal sequence
        w = 'h85;
        s = w + 'h7B;
        c = s >> 8;
        dc = ((w & 15) + ('h7B & 15)) >> 4;
        ov = ((~(w ^ 'h7B)) & (w ^ s)) >> 7 & 1;
        w = (s & 255) | 'hF0;
        z = (w == 0);
        n = w >> 7;
        p = w | (n << 12 | ov << 11 | z << 10 | dc << 9 | c << 8);
        apb(0, REG_CORE_STATE, 0);
        `CHK(rd, p | 1 << 13 | 5 << 17)
        apb(0, REG_PROG_COUNTER, 0);
        `CHK(rd, 32'h11)
        `CHK(table_addr, 20'h1)
        `CHK(table_wdata, 8'h5B)
        `CHK(nvm_write, 1'b0)
        `CHK(tw_n, 1)
        `CHK(wdt_n, 1)
        // Call, multiply, subtract, return, relative call, interrupt return
        wake_event <= 1;
        @(posedge clk);
        wake_event <= 0;
        while (fetch_addr !== 20'h14) @(posedge clk);
        repeat (4) @(posedge clk);
        s = 'h12 + (~w & 255) + 1;
        c = s >> 8 & 1;
        dc = (('h12 & 15) + (~w & 15) + 1) >> 4;
        ov = (('h12 ^ w) & ('h12 ^ s)) >> 7 & 1;
        w = s & 255;
        z = (w == 0);
        n = w >> 7;
        p = w | (n << 12 | ov << 11 | z << 10 | dc << 9 | c << 8);
        apb(0, REG_CORE_STATE, 0);
        `CHK(rd, p | 1 << 13 | 3 << 15 | 5 << 17)
        `CHK(rd[16:15], 2'h3)
        apb(0, REG_PROG_COUNTER, 0);
        `CHK(rd, 32'h14)
        `CHK(product, 16'h02D0)
        end_sim();
    end
endmodule
bind cltd_decoder cltd_decoder_props u_props (.clk(clk), .rst(rst),
    .wake_event(wake_event), .nvm_done(nvm_done), .port_pins(port_pins),
    .timer_zero_write(timer_zero_write), .fetch_addr(fetch_addr),
    .table_read(table_read), .table_write(table_write),
    .table_wdata(table_wdata), .table_rdata(table_rdata),
    .nvm_write(nvm_write), .wdt_clear(wdt_clear), .standby(standby),
    .port_readback(port_readback), .prescaler_clear(prescaler_clear));
